//--- hw/pdi_pkg.sv
// Purpose: shared constants and types for the pcm serial port with drop/insert
// Assumes: 32-bit avalon-mm register slave, byte addresses, one word per register
// Notes:   all offsets and reset values live here, and all field positions except the fbit mask bits
package pdi_pkg;
  // ******************************
  // register offsets (byte addresses)
  // ******************************
  localparam logic [5:0] REG_CTRL     = 6'h00;
  localparam logic [5:0] REG_FRAME    = 6'h04;
  localparam logic [5:0] REG_TX_OFS   = 6'h08;
  localparam logic [5:0] REG_RX_OFS   = 6'h0c;
  localparam logic [5:0] REG_DROP_LO  = 6'h10;
  localparam logic [5:0] REG_DROP_HI  = 6'h14;
  localparam logic [5:0] REG_INS_LO   = 6'h18;
  localparam logic [5:0] REG_INS_HI   = 6'h1c;
  localparam logic [5:0] REG_FBIT_MSK = 6'h20;
  localparam logic [5:0] REG_STATUS   = 6'h24;
  // ******************************
  // field positions
  // ******************************
  localparam int CTRL_FRAMED = 0;
  localparam int CTRL_ASYNC  = 1;
  localparam int CTRL_TX_INV = 2;
  localparam int CTRL_RX_INV = 3;
  localparam int CTRL_AUX    = 4;
  localparam int CTRL_MASTER = 5;
  localparam int CTRL_TX_SRC = 6;   // two bits
  localparam int CTRL_RX_SRC = 8;   // two bits
  localparam int CTRL_EXTINV = 10;
  localparam int FRM_SLOTS   = 0;   // six bits, slots minus one
  localparam int FRM_FBIT    = 7;
  localparam int FRM_FRAMES  = 8;   // five bits, frames minus one
  localparam int OFS_FRAME   = 16;  // frame offset field, bit offset at 0
  localparam int STS_ALIGNED = 0;
  localparam int STS_SYNCSEEN = 1;
  // ******************************
  // reset values and encodings
  // ******************************
  localparam logic [5:0] SLOTS_M1_RST  = 6'h1f;  // 32 slots
  localparam logic [4:0] FRAMES_M1_RST = 5'h0f;  // 16 frames
  localparam logic [1:0] TXSRC_TXCLK = 2'h0, TXSRC_RECOV = 2'h1, TXSRC_EXT = 2'h2;
  localparam logic [1:0] RXSRC_RECOV = 2'h0, RXSRC_EXT = 2'h1, RXSRC_TXCLK = 2'h2;

  typedef struct packed {
    logic framed, async_map, tx_inv, rx_inv, aux_sel, master_mode, ext_inv;
    logic [1:0] tx_src, rx_src;
    logic [5:0] slots_m1;
    logic       fbit_en;
    logic [4:0] frames_m1;
    logic [8:0] tx_bofs, rx_bofs;
    logic [4:0] tx_fofs, rx_fofs;
    logic [63:0] drop_mask, ins_mask;
    logic        drop_f, ins_f;
  } pdi_cfg_t;

  typedef struct packed {
    logic       rx_ser, rx_sync, drop, ins, tx_master_sync_out;
    logic [2:0] aux;
  } pdi_pins_t;

  typedef struct packed {
    logic ser, sync, alt;
  } pdi_txin_t;
endpackage

//--- hw/pdi_port.sv
// Purpose: pcm serial port time bases, drop/insert markers and register slave
// Assumes: I_LINK_CLK is the selected pcm bit clock; clock muxes sit at chip level
// Notes:   config crosses to the link by a toggle handshake held under waitrequest
//
// What this block does
// - tx inputs sampled on falling edge, insert marker on rising; edges invertible
// - tx timing selectable from tx clock, recovered clock or external clock
// - rx clock from recovery loop normally, else external or tx clock
// - rx outputs change on rising edge, or falling edge when inverted
// - external clock may time rx alone or both directions, either edge
// - accept up to 64 eight-bit slots plus optional framing bit into payload
// - output up to 64 slots plus optional framing bit from rx payload
// - rising tx frame sync resets tx time base only in framed synchronous use outside master mode
// - tx sync edge placed by programmable bit and frame offset
// - rx frame sync pulses one clock with bit 0 frame 0 in framed synchronous use
// - bit 0 is first bit of slot zero, or the framing bit if present
// - rx frame sync position set by programmable bit and frame delay
// - master sync pulses one clock, two clocks before bit 0 frame 0
// - master sync follows system sync or acts as master sync for system
// - drop marker high eight bits per marked slot, one for framing bit
// - alternate input replaces tx serial while insert marker active
// - insert marker high eight bits per marked slot, one for framing bit
// - marker and master sync pins shared with rx aux data by select bit
module pdi_port
  import pdi_pkg::*;
(
  input  wire logic        I_CLK,
  input  wire logic        I_RSTN,
  input  wire logic [5:0]  I_AVS_ADDRESS,
  input  wire logic        I_AVS_READ,
  input  wire logic        I_AVS_WRITE,
  input  wire logic [31:0] I_AVS_WRITEDATA,
  output logic      [31:0] O_AVS_READDATA,
  output logic             O_AVS_WAITREQUEST,
  input  wire logic        I_LINK_CLK,
  input  wire logic        I_PCM_TX_SERIAL,
  input  wire logic        I_TX_FRAME_SYNC_IN,
  input  wire logic        I_ALT_TX_SERIAL_IN,
  input  wire logic        I_RX_PAY_BIT,
  input  wire logic        I_RX_PAY_ALIGN,
  input  wire logic [2:0]  I_RX_AUX_DATA,
  output logic             O_TX_PAY_BIT,
  output logic             O_TX_PAY_BIT0,
  output logic             O_TX_PAY_FBIT,
  output logic             O_PCM_RX_SERIAL,
  output logic             O_RX_FRAME_SYNC_OUT,
  output logic [2:0]       O_AUX_PINS,
  output logic [1:0]       O_TX_CLK_SRC,
  output logic [1:0]       O_RX_CLK_SRC,
  output logic             O_EXT_CLK_INV
);
  // ******************************
  // resets and bus state
  // ******************************
  typedef enum logic [2:0] {S_IDLE = 3'b001, S_SYNC = 3'b010, S_DONE = 3'b100} pdi_st_t;

  logic      rst_s1_r, rst_n_r, lrst_s1_r, lrst_n_r;
  pdi_st_t   st_r;
  pdi_cfg_t  cfg_r, cfg_l_r;
  logic      req_r, ack_s1_r, ack_s2_r;
  logic      wait_r;
  logic [31:0] rdata_r;
  logic      seen_r, ali_s1_r, ali_s2_r, tg_s1_r, tg_s2_r, tg_s3_r;
  logic      req_s1_r, req_s2_r, ack_l_r, aligned_r, sync_tgl_r;  // link-side handshake state, plus alignment and sync toggle status

  // reset release through two flops per domain
  always_ff @(posedge I_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end
  always_ff @(posedge I_LINK_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      lrst_s1_r <= 1'b0;
      lrst_n_r  <= 1'b0;
    end else begin
      lrst_s1_r <= 1'b1;
      lrst_n_r  <= lrst_s1_r;
    end
  end

  // ******************************
  // register decode
  // ******************************
  wire       bus_idle = (st_r == S_IDLE);
  wire       do_wr    = bus_idle && I_AVS_WRITE;
  wire       do_rd    = bus_idle && I_AVS_READ && !I_AVS_WRITE;
  wire       ack_eq   = (ack_s2_r == req_r);
  wire       sync_ev  = tg_s2_r ^ tg_s3_r;
  wire [31:0] wd      = I_AVS_WRITEDATA;
  wire       clr_seen = do_wr && (I_AVS_ADDRESS == REG_STATUS) && wd[STS_SYNCSEEN];
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;  // unmapped reads return zero
    case (I_AVS_ADDRESS)
      REG_CTRL:     rd_mux = {21'h0, cfg_r.ext_inv, cfg_r.rx_src, cfg_r.tx_src,
                              cfg_r.master_mode, cfg_r.aux_sel, cfg_r.rx_inv,
                              cfg_r.tx_inv, cfg_r.async_map, cfg_r.framed};
      REG_FRAME:    rd_mux = {19'h0, cfg_r.frames_m1, cfg_r.fbit_en, 1'b0, cfg_r.slots_m1};
      REG_TX_OFS:   rd_mux = {11'h0, cfg_r.tx_fofs, 7'h0, cfg_r.tx_bofs};
      REG_RX_OFS:   rd_mux = {11'h0, cfg_r.rx_fofs, 7'h0, cfg_r.rx_bofs};
      REG_DROP_LO:  rd_mux = cfg_r.drop_mask[31:0];
      REG_DROP_HI:  rd_mux = cfg_r.drop_mask[63:32];
      REG_INS_LO:   rd_mux = cfg_r.ins_mask[31:0];
      REG_INS_HI:   rd_mux = cfg_r.ins_mask[63:32];
      REG_FBIT_MSK: rd_mux = {30'h0, cfg_r.ins_f, cfg_r.drop_f};
      REG_STATUS:   rd_mux = {30'h0, seen_r, ali_s2_r};
      default:      rd_mux = 32'h0;
    endcase
  end

  // bus handshake: a write holds waitrequest until the link has taken the config
  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      st_r    <= S_IDLE;
      wait_r  <= 1'b1;
      req_r   <= 1'b0;
      rdata_r <= 32'h0;
    end else begin
      case (st_r)
        S_IDLE: begin
          if (do_wr) begin
            req_r <= ~req_r;
            st_r  <= S_SYNC;
          end else if (do_rd) begin
            rdata_r <= rd_mux;
            wait_r  <= 1'b0;
            st_r    <= S_DONE;
          end
        end
        S_SYNC: begin
          if (ack_eq) begin
            wait_r <= 1'b0;
            st_r   <= S_DONE;
          end
        end
        S_DONE: begin
          wait_r <= 1'b1;
          st_r   <= S_IDLE;
        end
        default: begin
          wait_r <= 1'b1;
          st_r   <= S_IDLE;
        end
      endcase
    end
  end

  // configuration registers; masks read per position on the link
  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      cfg_r           <= '0;
      cfg_r.slots_m1  <= SLOTS_M1_RST;
      cfg_r.frames_m1 <= FRAMES_M1_RST;
    end else if (do_wr) begin
      case (I_AVS_ADDRESS)
        REG_CTRL: begin
          cfg_r.framed      <= wd[CTRL_FRAMED];
          cfg_r.async_map   <= wd[CTRL_ASYNC];
          cfg_r.tx_inv      <= wd[CTRL_TX_INV];
          cfg_r.rx_inv      <= wd[CTRL_RX_INV];
          cfg_r.aux_sel     <= wd[CTRL_AUX];
          cfg_r.master_mode <= wd[CTRL_MASTER];
          cfg_r.tx_src      <= wd[CTRL_TX_SRC +: 2];
          cfg_r.rx_src      <= wd[CTRL_RX_SRC +: 2];
          cfg_r.ext_inv     <= wd[CTRL_EXTINV];
        end
        REG_FRAME: begin
          cfg_r.slots_m1  <= wd[FRM_SLOTS +: 6];
          cfg_r.fbit_en   <= wd[FRM_FBIT];
          cfg_r.frames_m1 <= wd[FRM_FRAMES +: 5];
        end
        REG_TX_OFS: begin
          cfg_r.tx_bofs <= wd[8:0];
          cfg_r.tx_fofs <= wd[OFS_FRAME +: 5];
        end
        REG_RX_OFS: begin
          cfg_r.rx_bofs <= wd[8:0];
          cfg_r.rx_fofs <= wd[OFS_FRAME +: 5];
        end
        REG_DROP_LO:  cfg_r.drop_mask[31:0]  <= wd;
        REG_DROP_HI:  cfg_r.drop_mask[63:32] <= wd;
        REG_INS_LO:   cfg_r.ins_mask[31:0]   <= wd;
        REG_INS_HI:   cfg_r.ins_mask[63:32]  <= wd;
        REG_FBIT_MSK: {cfg_r.ins_f, cfg_r.drop_f} <= wd[1:0];
        default:      cfg_r <= cfg_r;
      endcase
    end
  end

  // ack, alignment level and sync-seen toggle come back from the link
  always_ff @(posedge I_CLK or negedge rst_n_r) begin
    if (!rst_n_r) begin
      {ack_s1_r, ack_s2_r, ali_s1_r, ali_s2_r} <= 4'h0;
      {tg_s1_r, tg_s2_r, tg_s3_r, seen_r}      <= 4'h0;
    end else begin
      ack_s1_r <= ack_l_r;
      ack_s2_r <= ack_s1_r;
      ali_s1_r <= aligned_r;
      ali_s2_r <= ali_s1_r;
      tg_s1_r  <= sync_tgl_r;
      tg_s2_r  <= tg_s1_r;
      tg_s3_r  <= tg_s2_r;
      seen_r   <= sync_ev | (seen_r & ~clr_seen);  // a new sync beats the clear
    end
  end

  assign O_AVS_WAITREQUEST = wait_r;
  assign O_AVS_READDATA    = rdata_r;
  assign O_TX_CLK_SRC      = cfg_r.tx_src;   // drives the chip-level clock mux
  assign O_RX_CLK_SRC      = cfg_r.rx_src;
  assign O_EXT_CLK_INV     = cfg_r.ext_inv;

  // ******************************
  // link domain: config handshake
  // ******************************

  // cfg_r is stable while the request is open, so a whole-word copy is safe
  always_ff @(posedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      {req_s1_r, req_s2_r, ack_l_r} <= 3'h0;
      cfg_l_r                       <= '0;
      cfg_l_r.slots_m1              <= SLOTS_M1_RST;
      cfg_l_r.frames_m1             <= FRAMES_M1_RST;
    end else begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
      if (req_s2_r != ack_l_r) begin
        cfg_l_r <= cfg_r;
        ack_l_r <= req_s2_r;
      end
    end
  end

  // mask lookup: position 0 is the framing bit when enabled
  function automatic logic mark(input logic [9:0] p, input logic fb,
                                input logic [63:0] m, input logic fm);
    logic [9:0] q;
    q = p - {9'h0, fb};
    if (fb && (p == 10'h0)) mark = fm;
    else mark = m[q[8:3]];
  endfunction

  // frame length in bits, less one: optional framing bit plus 8 per slot
  wire [9:0] len_m1 = {1'b0, cfg_l_r.slots_m1, 3'h7} + {9'h0, cfg_l_r.fbit_en};
  wire       sync_use = cfg_l_r.framed && !cfg_l_r.async_map;

  // ******************************
  // transmit side
  // ******************************
  pdi_txin_t tx_n_r, tx_p_r, tx_s_r;
  logic      sync_d_r, ins_r, tx_master_sync_out_r, txb_r, txb0_r, txf_r;
  logic [9:0] tx_pos_r, tx_pos_nx;
  logic [4:0] tx_frm_r, tx_frm_nx;

  // both edges captured; the configured one feeds the time base
  always_ff @(negedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) tx_n_r <= '0;
    else tx_n_r <= '{I_PCM_TX_SERIAL, I_TX_FRAME_SYNC_IN, I_ALT_TX_SERIAL_IN};
  end
  always_ff @(posedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) tx_p_r <= '0;
    else tx_p_r <= '{I_PCM_TX_SERIAL, I_TX_FRAME_SYNC_IN, I_ALT_TX_SERIAL_IN};
  end

  wire tx_sel_sync = cfg_l_r.tx_inv ? tx_p_r.sync : tx_n_r.sync;
  // rising sync restarts the count in framed synchronous use, unless free-running as sync master
  wire sync_rise   = tx_s_r.sync && !sync_d_r;
  wire accept      = sync_rise && sync_use && !cfg_l_r.master_mode;
  wire tx_wrap     = (tx_pos_r == len_m1);

  // the sync edge lands on the programmed bit and frame offset
  always_comb begin
    tx_pos_nx = tx_wrap ? 10'h0 : tx_pos_r + 10'h1;
    tx_frm_nx = !tx_wrap ? tx_frm_r :
                (tx_frm_r == cfg_l_r.frames_m1) ? 5'h0 : tx_frm_r + 5'h1;
    if (accept) begin
      tx_pos_nx = {1'b0, cfg_l_r.tx_bofs};
      tx_frm_nx = cfg_l_r.tx_fofs;
    end
  end

  always_ff @(posedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      tx_s_r     <= '0;
      sync_d_r   <= 1'b0;
      tx_pos_r   <= 10'h0;
      tx_frm_r   <= 5'h0;
      {ins_r, tx_master_sync_out_r, txb_r, txb0_r, txf_r} <= 5'h0;
      aligned_r  <= 1'b0;
      sync_tgl_r <= 1'b0;
    end else begin
      tx_s_r   <= cfg_l_r.tx_inv ? tx_p_r : tx_n_r;
      sync_d_r <= tx_s_r.sync;
      tx_pos_r <= tx_pos_nx;
      tx_frm_r <= tx_frm_nx;
      ins_r    <= mark(tx_pos_nx, cfg_l_r.fbit_en, cfg_l_r.ins_mask, cfg_l_r.ins_f);
      // two positions ahead of bit 0 frame 0
      tx_master_sync_out_r  <= (tx_frm_nx == cfg_l_r.frames_m1) && (tx_pos_nx == len_m1 - 10'h1);
      txb_r    <= ins_r ? tx_s_r.alt : tx_s_r.ser;
      txb0_r   <= (tx_pos_r == 10'h0) && (tx_frm_r == 5'h0);
      txf_r    <= cfg_l_r.fbit_en && (tx_pos_r == 10'h0);
      if (accept) begin
        aligned_r  <= 1'b1;
        sync_tgl_r <= ~sync_tgl_r;
      end else if (!sync_use) begin
        aligned_r  <= 1'b0;
      end
    end
  end

  // ******************************
  // receive side
  // ******************************
  logic [9:0] rx_pos_r, rx_pos_nx;
  logic [4:0] rx_frm_r, rx_frm_nx;
  pdi_pins_t  pins_p_r, pins_n_r, pins_nx;
  wire        rx_wrap = (rx_pos_r == len_m1);

  // mapper alignment marks bit 0 frame 0 of the rebuilt stream
  always_comb begin
    rx_pos_nx = rx_wrap ? 10'h0 : rx_pos_r + 10'h1;
    rx_frm_nx = !rx_wrap ? rx_frm_r :
                (rx_frm_r == cfg_l_r.frames_m1) ? 5'h0 : rx_frm_r + 5'h1;
    if (I_RX_PAY_ALIGN) begin
      rx_pos_nx = 10'h0;
      rx_frm_nx = 5'h0;
    end
  end

  // pin values; aux select swaps markers for rx aux data
  always_comb begin
    pins_nx.rx_ser  = I_RX_PAY_BIT;
    pins_nx.rx_sync = sync_use && (rx_pos_nx == {1'b0, cfg_l_r.rx_bofs}) &&
                      (rx_frm_nx == cfg_l_r.rx_fofs);
    pins_nx.drop    = mark(rx_pos_nx, cfg_l_r.fbit_en, cfg_l_r.drop_mask,
                           cfg_l_r.drop_f);
    pins_nx.ins     = ins_r;
    pins_nx.tx_master_sync_out   = tx_master_sync_out_r;
    pins_nx.aux     = cfg_l_r.aux_sel ? I_RX_AUX_DATA : {tx_master_sync_out_r, ins_r, pins_nx.drop};
  end

  always_ff @(posedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) begin
      rx_pos_r <= 10'h0;
      rx_frm_r <= 5'h0;
      pins_p_r <= '0;
    end else begin
      rx_pos_r <= rx_pos_nx;
      rx_frm_r <= rx_frm_nx;
      pins_p_r <= pins_nx;
    end
  end
  // half-cycle copy serves the inverted edge choice
  always_ff @(negedge I_LINK_CLK or negedge lrst_n_r) begin
    if (!lrst_n_r) pins_n_r <= '0;
    else pins_n_r <= pins_p_r;
  end

  // each pin picks the flop of its edge; rx outputs follow rx polarity
  wire tx_edge_inv = cfg_l_r.tx_inv;
  wire rx_edge_inv = cfg_l_r.rx_inv;
  wire aux_tx_edge = !cfg_l_r.aux_sel;
  assign O_PCM_RX_SERIAL     = rx_edge_inv ? pins_n_r.rx_ser : pins_p_r.rx_ser;
  assign O_RX_FRAME_SYNC_OUT = rx_edge_inv ? pins_n_r.rx_sync : pins_p_r.rx_sync;
  assign O_AUX_PINS[0]       = rx_edge_inv ? pins_n_r.aux[0] : pins_p_r.aux[0];
  assign O_AUX_PINS[2:1]     = ((aux_tx_edge && tx_edge_inv) ||
                                (!aux_tx_edge && rx_edge_inv)) ?
                               pins_n_r.aux[2:1] : pins_p_r.aux[2:1];
  assign O_TX_PAY_BIT        = txb_r;
  assign O_TX_PAY_BIT0       = txb0_r;
  assign O_TX_PAY_FBIT       = txf_r;

  // ******************************
  // checks
  // ******************************
  sequence s_no_reload;
    !accept ##1 !accept;
  endsequence

  chk_rx_sync_width: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    pins_p_r.rx_sync |=> !pins_p_r.rx_sync)
    else $error("rx frame sync wider than one clock");
  chk_sync_load: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    accept |=> (tx_pos_r == {1'b0, $past(cfg_l_r.tx_bofs)}))
    else $error("tx sync did not load bit offset");
  chk_sync_ignored: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    (sync_rise && !sync_use && !tx_wrap) |=> (tx_pos_r == $past(tx_pos_r) + 10'h1))
    else $error("tx sync acted in unframed mode");
  chk_tx_master_sync_out_lead: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    (tx_master_sync_out_r && !accept) ##0 s_no_reload |-> ##1 (tx_pos_r == 10'h0 && tx_frm_r == 5'h0))
    else $error("master sync not two clocks ahead");
  chk_insert_sub: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    ##1 (txb_r == ($past(ins_r) ? $past(tx_s_r.alt) : $past(tx_s_r.ser))))
    else $error("insert substitution wrong");
  chk_drop_fbit: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    (cfg_l_r.fbit_en && rx_pos_nx == 10'h0) |=> (pins_p_r.drop == $past(cfg_l_r.drop_f)))
    else $error("drop marker wrong on framing bit");
  chk_aux_data: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    cfg_l_r.aux_sel |=> (pins_p_r.aux == $past(I_RX_AUX_DATA)))
    else $error("aux pins not carrying aux data");
  chk_write_wait: assert property (@(posedge I_CLK) disable iff (!rst_n_r)
    do_wr |=> wait_r [*2])
    else $error("write answered before link took config");
  chk_read_time: assert property (@(posedge I_CLK) disable iff (!rst_n_r)
    do_rd |=> !wait_r ##1 wait_r)
    else $error("read answer not one cycle");
  chk_tx_edge_sel: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_n_r)
    ##1 (tx_s_r.sync == $past(tx_sel_sync)))
    else $error("tx sync not taken from the selected edge");
endmodule

//--- testbench/pdi_framer_model.sv
// Purpose: far-side pcm framer and rx payload source for the serial port bench
// Assumes: link clock runs free; tx pins sampled by the port on the falling edge
// Notes:   fixed pattern: tx serial 0, alternate data 1, aux data constant
module pdi_framer_model
  import pdi_pkg::*;
#(
  parameter int MF = 34
)
(
  input  wire logic       i_clk,
  input  wire logic       i_rstn,
  output logic            o_tx_ser,
  output logic            o_tx_sync,
  output logic            o_alt,
  output logic            o_pay_bit,
  output logic            o_pay_align,
  output logic [2:0]      o_aux
);
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************
  // multiframe time base
  // ******************************
  int pos_r;
  int pos_nxt;
  assign pos_nxt = (pos_r == MF - 1) ? 0 : pos_r + 1;
  // drive on rising edge so the falling-edge sample sees half a cycle of setup
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      pos_r       <= 0;
      o_tx_sync   <= 1'b0;
      o_pay_align <= 1'b0;
      o_pay_bit   <= 1'b0;
      o_tx_ser    <= 1'b0;
      o_alt       <= 1'b0;
      o_aux       <= 3'h0;
    end else begin
      pos_r       <= pos_nxt;
      o_tx_sync   <= (pos_nxt < 2);               // rising at bit 0 frame 0
      o_pay_align <= (pos_nxt == 0);
      o_pay_bit   <= pos_nxt[0] ^ pos_nxt[2];
      o_tx_ser    <= 1'b0;
      o_alt       <= 1'b1;                        // same frame format as tx serial
      o_aux       <= 3'h5;
    end
  end
endmodule

//--- testbench/pdi_port_test.sv
// Purpose: self-checking bench for the pcm serial port with drop/insert
// Assumes: frame of framing bit plus two slots, two frames per multiframe
// Notes:   marker counts are taken over each 34-cycle multiframe, starting at bit 0 frame 0
module pdi_port_test
  import pdi_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ******************************
  // signals and instances
  // ******************************
  localparam int FL = 17;
  localparam int MF = 34;
  logic        clk, lclk, rstn, rd_s, wr_s, wait_s;
  logic [5:0]  adr;
  logic [31:0] wdat, rdat, rv;
  logic        pcm_tx_serial, tsync, alt, pbit, palign, txb, txb0, txf, pcm_rx_serial, rsync, einv;
  logic [2:0]  auxin, aux;
  logic [1:0]  tsrc, rsrc;
  logic        tx_on = 0, rx_on = 0, tx_arm = 0, rlock = 0, h_bit, h_al;
  int          error_cnt = 0, n_tests = 0, tx_len, tx_one, ins_n, ms_n, rpos, fp, fb_n;
  pdi_port pdi_port_inst (.I_CLK(clk), .I_RSTN(rstn), .I_AVS_ADDRESS(adr), .I_AVS_READ(rd_s),
    .I_AVS_WRITE(wr_s), .I_AVS_WRITEDATA(wdat), .O_AVS_READDATA(rdat),
    .O_AVS_WAITREQUEST(wait_s), .I_LINK_CLK(lclk), .I_PCM_TX_SERIAL(pcm_tx_serial),
    .I_TX_FRAME_SYNC_IN(tsync), .I_ALT_TX_SERIAL_IN(alt), .I_RX_PAY_BIT(pbit),
    .I_RX_PAY_ALIGN(palign), .I_RX_AUX_DATA(auxin), .O_TX_PAY_BIT(txb),
    .O_TX_PAY_BIT0(txb0), .O_TX_PAY_FBIT(txf), .O_PCM_RX_SERIAL(pcm_rx_serial),
    .O_RX_FRAME_SYNC_OUT(rsync), .O_AUX_PINS(aux), .O_TX_CLK_SRC(tsrc),
    .O_RX_CLK_SRC(rsrc), .O_EXT_CLK_INV(einv));
  pdi_framer_model #(.MF(MF)) pdi_framer_model_inst (.i_clk(lclk), .i_rstn(rstn),
    .o_tx_ser(pcm_tx_serial), .o_tx_sync(tsync), .o_alt(alt), .o_pay_bit(pbit),
    .o_pay_align(palign), .o_aux(auxin));
  // two unrelated clocks: 40 ns system, 15 ns link
  initial begin
    clk = 0;
    forever #20 clk = ~clk;
  end
  initial begin
    lclk = 0;
    #3.3;
    forever #7.5 lclk = ~lclk;
  end
  // ******************************
  // tasks
  // ******************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one avalon access; request held until waitrequest is sampled low
  task automatic acc(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    rd_s <= !w;
    wr_s <= w;
    adr  <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wait_s !== 1'b0 && n < 200);
    rv = rdat;
    rd_s <= 1'b0;
    wr_s <= 1'b0;
    if (n >= 200) chk("bus answer", 1, 0);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // ******************************
  // link monitors
  // ******************************
  // blocking reads see the value present before the partner's update
  always @(posedge lclk) begin
    h_bit = pbit;
    h_al = palign;
  end
  // falling edge: rising-edge outputs have settled for half a cycle
  always @(negedge lclk) begin
    rpos = h_al ? 0 : (rpos + 1) % MF;
    if (h_al) rlock = 1;
    fp = rpos % FL;
    if (rx_on && rlock) begin
      chk("rx serial", pcm_rx_serial, h_bit);
      chk("rx sync", rsync, h_al);
      chk("drop marker", aux[0], fp == 0 || fp >= 9);
    end
    if (tx_on) begin
      if (txb0 === 1'b1) begin
        if (tx_arm) begin
          chk("tx multiframe", tx_len, MF);
          chk("tx inserted ones", tx_one, 16);
          chk("insert marker", ins_n, 16);
          chk("master sync", ms_n, 1);
          chk("framing bits", fb_n, 2);
        end
        tx_arm = 1;
        tx_len = 0;
        tx_one = 0;
        ins_n = 0;
        ms_n = 0;
        fb_n = 0;
      end
      tx_len++;
      fb_n += int'(txf);
      tx_one += int'(txb);
      ins_n += int'(aux[1]);
      ms_n += int'(aux[2]);
    end
  end
  // ******************************
  // main sequence and watchdog
  // ******************************
  initial begin
    {rd_s, wr_s, adr, wdat} = '0;
    rstn = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    chk("clock selects", {tsrc, rsrc, einv}, 0);
    acc(0, REG_FRAME, 0);
    chk("frame reset", rv, (32'(FRAMES_M1_RST) << FRM_FRAMES) | 32'(SLOTS_M1_RST));
    acc(1, 6'h28, '1);
    acc(0, 6'h28, 0);
    chk("unmapped", rv, 0);
    for (int i = 0; i < 3; i++) begin
      acc(1, REG_CTRL, (32'(i) << CTRL_TX_SRC) | (32'(2 - i) << CTRL_RX_SRC)
          | (32'(i & 1) << CTRL_EXTINV) | 32'h1);
      chk("tx source", tsrc, i);
      chk("rx source", rsrc, 2 - i);
      chk("ext invert", einv, i & 1);
    end
    acc(1, REG_FRAME, 32'h0000_0181);
    acc(1, REG_DROP_LO, 32'h2);
    acc(1, REG_INS_LO, 32'h1);
    acc(1, REG_FBIT_MSK, 32'h1);
    acc(1, REG_CTRL, 32'h1);
    repeat (60) @(posedge clk);
    rx_on = 1;
    tx_on = 1;
    repeat (300) @(posedge clk);
    acc(0, REG_STATUS, 0);
    chk("sync seen", rv[1], 1);
    chk("aligned", rv[0], 1);
    acc(0, REG_DROP_LO, 0);
    chk("drop mask", rv, 32'h2);
    rx_on = 0;
    tx_on = 0;
    // master mode ignores the system sync, so a cleared sticky flag stays clear
    acc(1, REG_CTRL, 32'h21);
    repeat (5) @(posedge clk);
    acc(1, REG_STATUS, 32'h2);
    repeat (40) @(posedge clk);
    acc(0, REG_STATUS, 0);
    chk("sync seen clear", rv[1], 0);
    chk("aligned master", rv[0], 1);
    // asynchronous mapping drops the alignment
    acc(1, REG_CTRL, 32'h3);
    repeat (10) @(posedge clk);
    acc(0, REG_STATUS, 0);
    chk("aligned async", rv[0], 0);
    acc(1, REG_CTRL, 32'h11);
    repeat (10) @(posedge clk);
    chk("aux pins", aux, 3'h5);
    final_report();
  end
  // whole run is well under 2000 system cycles
  initial begin
    #200000;
    error_cnt++;
    final_report();
  end
endmodule
